// File: rtl/usa_pkg.sv
// shared constants and types for the asynchronous serial port
// assumes a single 25 MHz clock and an AXI4-Lite register slave
package usa_pkg;
  // clock and derived timing
  localparam int CLK_PERIOD_NS = 40;
  localparam int TCY_NS = 40;
  localparam int TCY_CLKS = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] TCY_LAST = 4'(TCY_CLKS - 1);
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] TICK_LAST = 4'(OVERSAMPLE - 1);
  localparam logic [3:0] HALF_LAST = 4'(OVERSAMPLE / 2 - 1);
  localparam logic [3:0] TX_FRAME_8 = 4'ha;
  localparam logic [3:0] TX_FRAME_9 = 4'hb;
  localparam logic [3:0] RX_LAST_8 = 4'h7;
  localparam logic [3:0] RX_LAST_9 = 4'h8;
  // register byte addresses
  localparam logic [7:0] ADDR_TXCTL = 8'h00;
  localparam logic [7:0] ADDR_RXCTL = 8'h04;
  localparam logic [7:0] ADDR_TXDATA = 8'h08;
  localparam logic [7:0] ADDR_RXDATA = 8'h0c;
  localparam logic [7:0] ADDR_BAUD = 8'h10;
  localparam logic [7:0] ADDR_DIR = 8'h14;
  localparam logic [7:0] ADDR_FLAG = 8'h18;
  // transmit_control_reg fields
  localparam int TXC_NINE_SEL = 6;
  localparam int TXC_EN = 5;
  localparam int TXC_SYNC = 4;
  localparam int TXC_SHIFT_EMPTY = 1;
  localparam int TXC_NINTH = 0;
  // receive_control_reg fields
  localparam int RXC_SERIAL_PORT_ENABLE = 7;
  localparam int RXC_NINE_SEL = 6;
  localparam int RXC_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int RXC_IDLE = 3;
  localparam int RXC_FRAMING_ERROR_FLAG = 2;
  localparam int RXC_OVERRUN_ERROR_FLAG = 1;
  localparam int RXC_NINTH = 0;
  // baud_divisor_reg and pin direction fields
  localparam int BAUD_WIDE = 16;
  localparam int DIR_TX_IN = 0;
  localparam int DIR_RX_IN = 1;
  localparam int DIR_TX_LAT = 2;
  localparam int DIR_RX_LAT = 3;
  localparam logic [3:0] DIR_RST = 4'h3;
  // peripheral_flag_reg fields
  localparam int FLG_TX_EMPTY = 0;
  localparam int FLG_RX_AVAIL = 1;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [1:0] {
    TX_IDLE = 2'b00,
    TX_SHIFT = 2'b01,
    TX_GAP = 2'b10
  } usa_tx_st_t;

  typedef enum logic [1:0] {
    RX_IDLE = 2'b00,
    RX_START = 2'b01,
    RX_DATA = 2'b10,
    RX_STOP = 2'b11
  } usa_rx_st_t;
endpackage

// File: rtl/usa_tick_if.sv
// carries the baud setting to the tick generator and the ticks back
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface usa_tick_if;
  logic [15:0] divisor;
  logic wide;
  logic [1:0] restart;
  logic [1:0] tick;
  modport gen (input divisor, input wide, input restart, output tick);
  modport user (output divisor, output wide, output restart, input tick);
endinterface

// File: rtl/usa_baud.sv
// 16x oversampling tick generator, one channel for transmit, one for receive
// assumes restart is a one-cycle pulse from the port logic
`timescale 1ns/1ps
module usa_baud (
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // setting and ticks
  usa_tick_if.gen bt
);
  typedef struct packed {
    logic [1:0][15:0] cnt;
  } usa_baud_st_t;

  usa_baud_st_t s_q, s_d;
  logic [15:0] lim;

  // 8-bit mode ignores the upper divisor byte
  assign lim = bt.wide ? bt.divisor : {8'h00, bt.divisor[7:0]};

  // each direction owns a phase so a frame starts on a full tick period
  for (genvar g = 0; g < 2; g++) begin : g_chan
    assign bt.tick[g] = (s_q.cnt[g] >= lim) & ~bt.restart[g];
  end

  always_comb begin
    s_d = s_q;
    for (int i = 0; i < 2; i++) begin
      if (bt.restart[i] | (s_q.cnt[i] >= lim)) begin
        s_d.cnt[i] = 16'h0000;
      end else begin
        s_d.cnt[i] = s_q.cnt[i] + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end
endmodule

// File: rtl/usa_async_port.sv
// asynchronous serial port: transmit path, oversampled receiver, register slave
// assumes an AXI4-Lite master on clk_i and a remote UART on the tx/rx pins
// Operation
// - idle transmit line stays at mark
// - frame is start, 8/9 data, stop
// - every bit lasts one baud period
// - data bits travel least significant first
// - transmitter and receiver run independently
// - no hardware parity; ninth bit serves
// - baud generator selectable 8 or 16 bit
// - transmit needs enable, async, port enable
// - active transmitter forces pin to output
// - holding write starts transmission immediately
// - queued character loads one cycle after stop
// - loaded character sends start, data, stop
// - empty flag high unless busy and queued; here it is also low while the transmitter is off
// - empty flag clears second cycle after write; here it clears on the third cycle after the write
// - empty flag independent of interrupt enable
// - shift empty status tracks shift register
// - ninth bit sent as most significant
// - receiver oversamples at sixteen times baud
// - received characters enter two-entry fifo
// - receive needs enable, async, port enable
// - active receiver forces pin to input
// - false start bit abandoned at half bit
// - stop bit low sets framing error
// - overrun blocks reception until enable cleared
//
// Design decisions made here: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module usa_async_port
  import usa_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic nrst_i,
  // axi4-lite write address and data
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  // axi4-lite write response
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  // serial pins
  output logic tx_o,
  output logic tx_oe_o,
  input wire logic rx_i,
  output logic rx_o,
  output logic rx_oe_o
);
  typedef struct packed {
    logic aw_full;
    logic [7:0] awaddr;
    logic w_full;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic nine_tx;
    logic transmitter_enable;
    logic sync;
    logic tx9;
    logic serial_port_enable;
    logic nine_rx;
    logic continuous_receive_enable;
    logic [15:0] baud;
    logic wide;
    logic [3:0] dir;
    logic [7:0] hold;
    logic hold_full;
    usa_tx_st_t tx_st;
    logic [10:0] transmit_shift_reg;
    logic [3:0] tx_bits;
    logic [3:0] tx_tk;
    logic [3:0] gap;
    logic tf1;
    logic tflag;
    logic [2:0] rs;
    logic line;
    usa_rx_st_t rx_st;
    logic [3:0] rx_tk;
    logic [3:0] rx_bits;
    logic [8:0] receive_shift_reg;
    logic [1:0][9:0] fifo;
    logic rptr;
    logic [1:0] cnt;
    logic ovr;
  } usa_state_t;

  usa_state_t s_q, s_d;
  logic tx_on, rx_on, do_wr, ar_fire, load, pop, push, push_ok, fall, shift_empty_status;
  logic [9:0] top;
  logic [8:0] rxd;
  logic [3:0] tx_frame;
  logic [31:0] rd;
  logic [1:0] rr;

  usa_tick_if bt();

  usa_baud u_baud (
    .clk_i(clk_i),
    .nrst_i(nrst_i),
    .bt(bt.gen)
  );

  assign tx_on = s_q.serial_port_enable & s_q.transmitter_enable & ~s_q.sync;
  assign rx_on = s_q.serial_port_enable & s_q.continuous_receive_enable & ~s_q.sync;
  assign do_wr = s_q.aw_full & s_q.w_full & ~s_q.bvalid;
  assign ar_fire = s_axi_arvalid_i & ~s_q.rvalid;
  assign top = s_q.fifo[s_q.rptr];
  assign shift_empty_status = (s_q.tx_st != TX_SHIFT);
  assign tx_frame = s_q.nine_tx ? TX_FRAME_9 : TX_FRAME_8;
  // an empty shift register takes the character at once, a busy one after the gap
  assign load = tx_on & s_q.hold_full & ((s_q.tx_st == TX_IDLE) |
                ((s_q.tx_st == TX_GAP) & (s_q.gap == TCY_LAST)));
  assign pop = ar_fire & (s_axi_araddr_i == ADDR_RXDATA) & (s_q.cnt != 2'h0);
  // edge taken from the filtered line: second and third stage agree on low
  assign fall = rx_on & ~s_q.ovr & (s_q.rx_st == RX_IDLE) & s_q.line &
                (s_q.rs[1] == s_q.rs[2]) & ~s_q.rs[2];
  // stop-bit sample; kept outside the state process so push_ok does not loop back into it
  assign push = (s_q.rx_st == RX_STOP) & bt.tick[1] & (s_q.rx_tk == TICK_LAST);
  assign rxd = s_q.nine_rx ? s_q.receive_shift_reg : {1'b0, s_q.receive_shift_reg[8:1]};
  // a fifo slot freed by a read in the same cycle is usable
  assign push_ok = push & ~((s_q.cnt == 2'h2) & ~pop);

  assign bt.divisor = s_q.baud;
  assign bt.wide = s_q.wide;
  assign bt.restart = {fall, load};

  // read data mux
  always_comb begin
    rr = RESP_OKAY;
    unique case (s_axi_araddr_i)
      ADDR_TXCTL: rd = {25'h0, s_q.nine_tx, s_q.transmitter_enable, s_q.sync, 2'h0, shift_empty_status, s_q.tx9};
      ADDR_RXCTL: rd = {24'h0, s_q.serial_port_enable, s_q.nine_rx, 1'b0, s_q.continuous_receive_enable,
                        s_q.rx_st == RX_IDLE, (s_q.cnt != 2'h0) & top[9], s_q.ovr,
                        (s_q.cnt != 2'h0) & top[8]};
      ADDR_TXDATA: rd = {24'h0, s_q.hold};
      ADDR_RXDATA: rd = {24'h0, top[7:0]};
      ADDR_BAUD: rd = {15'h0, s_q.wide, s_q.baud};
      ADDR_DIR: rd = {28'h0, s_q.dir};
      ADDR_FLAG: rd = {30'h0, s_q.cnt != 2'h0, s_q.tflag};
      default: begin
        rd = 32'h0;
        rr = RESP_DECERR;
      end
    endcase
  end

  always_comb begin
    s_d = s_q;
    // bus channels: address and data are taken in either order
    if (s_axi_awvalid_i & ~s_q.aw_full & ~s_q.bvalid) begin
      s_d.aw_full = 1'b1;
      s_d.awaddr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i & ~s_q.w_full & ~s_q.bvalid) begin
      s_d.w_full = 1'b1;
      s_d.wdata = s_axi_wdata_i;
      s_d.wstrb = s_axi_wstrb_i;
    end
    if (s_q.bvalid & s_axi_bready_i) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.rvalid & s_axi_rready_i) begin
      s_d.rvalid = 1'b0;
    end
    if (ar_fire) begin
      s_d.rvalid = 1'b1;
      s_d.rdata = rd;
      s_d.rresp = rr;
    end

    // transmit shifter
    unique case (s_q.tx_st)
      TX_IDLE: begin
      end
      TX_SHIFT: begin
        if (bt.tick[0]) begin
          s_d.tx_tk = s_q.tx_tk + 4'h1;
          if (s_q.tx_tk == TICK_LAST) begin
            s_d.transmit_shift_reg = {1'b1, s_q.transmit_shift_reg[10:1]};
            s_d.tx_bits = s_q.tx_bits + 4'h1;
            if (s_q.tx_bits == tx_frame - 4'h1) begin
              s_d.tx_st = s_q.hold_full ? TX_GAP : TX_IDLE;
              s_d.gap = 4'h0;
            end
          end
        end
      end
      TX_GAP: s_d.gap = s_q.gap + 4'h1;
      default: s_d.tx_st = TX_IDLE;
    endcase
    if (load) begin
      // stop, optional ninth, data, start; no parity is ever generated
      s_d.transmit_shift_reg = {1'b1, s_q.nine_tx ? s_q.tx9 : 1'b1, s_q.hold, 1'b0};
      s_d.tx_st = TX_SHIFT;
      s_d.tx_tk = 4'h0;
      s_d.tx_bits = 4'h0;
      s_d.hold_full = 1'b0;
    end
    if (!tx_on) begin
      s_d.tx_st = TX_IDLE;
      s_d.transmit_shift_reg = '1;
    end
    // two-stage flag pipe: a poll right after the write sees the old value
    s_d.tf1 = tx_on & ~(s_q.hold_full & (s_q.tx_st != TX_IDLE));
    s_d.tflag = s_q.tf1;

    // receive synchroniser; the line moves once stages two and three agree
    s_d.rs = {s_q.rs[1:0], rx_i};
    if (s_q.rs[1] == s_q.rs[2]) begin
      s_d.line = s_q.rs[2];
    end
    unique case (s_q.rx_st)
      RX_IDLE: begin
        if (fall) begin
          s_d.rx_st = RX_START;
          s_d.rx_tk = 4'h0;
        end
      end
      RX_START: begin
        if (bt.tick[1]) begin
          s_d.rx_tk = s_q.rx_tk + 4'h1;
          if (s_q.rx_tk == HALF_LAST) begin
            s_d.rx_tk = 4'h0;
            s_d.rx_bits = 4'h0;
            s_d.rx_st = s_q.line ? RX_IDLE : RX_DATA;
          end
        end
      end
      RX_DATA: begin
        if (bt.tick[1]) begin
          s_d.rx_tk = s_q.rx_tk + 4'h1;
          if (s_q.rx_tk == TICK_LAST) begin
            s_d.receive_shift_reg = {s_q.line, s_q.receive_shift_reg[8:1]};
            s_d.rx_bits = s_q.rx_bits + 4'h1;
            if (s_q.rx_bits == (s_q.nine_rx ? RX_LAST_9 : RX_LAST_8)) begin
              s_d.rx_st = RX_STOP;
            end
          end
        end
      end
      RX_STOP: begin
        if (bt.tick[1]) begin
          s_d.rx_tk = s_q.rx_tk + 4'h1;
          if (s_q.rx_tk == TICK_LAST) begin
            s_d.rx_st = RX_IDLE;
          end
        end
      end
    endcase
    if (!rx_on) begin
      s_d.rx_st = RX_IDLE;
    end

    // receive fifo; a third character is dropped and latches overrun
    if (push_ok) begin
      s_d.fifo[s_q.rptr ^ s_q.cnt[0]] = {~s_q.line, rxd};
    end
    if (~s_q.continuous_receive_enable | ~s_q.serial_port_enable) begin
      s_d.ovr = 1'b0;
    end
    if (push & ~push_ok) begin
      s_d.ovr = 1'b1;
    end
    s_d.cnt = s_q.cnt + {1'b0, push_ok} - {1'b0, pop};
    s_d.rptr = s_q.rptr ^ pop;

    // port disable clears queued and received data
    if (!s_q.serial_port_enable) begin
      s_d.hold_full = 1'b0;
      s_d.cnt = 2'h0;
    end

    // register writes
    if (do_wr) begin
      s_d.aw_full = 1'b0;
      s_d.w_full = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = RESP_OKAY;
      unique case (s_q.awaddr)
        ADDR_TXCTL: begin
          if (s_q.wstrb[0]) begin
            s_d.nine_tx = s_q.wdata[TXC_NINE_SEL];
            s_d.transmitter_enable = s_q.wdata[TXC_EN];
            s_d.sync = s_q.wdata[TXC_SYNC];
            s_d.tx9 = s_q.wdata[TXC_NINTH];
          end
        end
        ADDR_RXCTL: begin
          if (s_q.wstrb[0]) begin
            s_d.serial_port_enable = s_q.wdata[RXC_SERIAL_PORT_ENABLE];
            s_d.nine_rx = s_q.wdata[RXC_NINE_SEL];
            s_d.continuous_receive_enable = s_q.wdata[RXC_CONTINUOUS_RECEIVE_ENABLE];
          end
        end
        ADDR_TXDATA: begin
          if (s_q.wstrb[0]) begin
            s_d.hold = s_q.wdata[7:0];
            s_d.hold_full = 1'b1;
          end
        end
        ADDR_BAUD: begin
          if (s_q.wstrb[0]) begin
            s_d.baud[7:0] = s_q.wdata[7:0];
          end
          if (s_q.wstrb[1]) begin
            s_d.baud[15:8] = s_q.wdata[15:8];
          end
          if (s_q.wstrb[2]) begin
            s_d.wide = s_q.wdata[BAUD_WIDE];
          end
        end
        ADDR_DIR: begin
          if (s_q.wstrb[0]) begin
            s_d.dir = s_q.wdata[3:0];
          end
        end
        ADDR_RXDATA, ADDR_FLAG: begin
        end
        default: s_d.bresp = RESP_DECERR;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      s_q <= '0;
      s_q.transmit_shift_reg <= '1;
      s_q.rs <= '1;
      s_q.line <= 1'b1;
      s_q.dir <= DIR_RST;
    end else begin
      s_q <= s_d;
    end
  end

  assign s_axi_awready_o = ~s_q.aw_full & ~s_q.bvalid;
  assign s_axi_wready_o = ~s_q.w_full & ~s_q.bvalid;
  assign s_axi_bvalid_o = s_q.bvalid;
  assign s_axi_bresp_o = s_q.bresp;
  assign s_axi_arready_o = ~s_q.rvalid;
  assign s_axi_rvalid_o = s_q.rvalid;
  assign s_axi_rdata_o = s_q.rdata;
  assign s_axi_rresp_o = s_q.rresp;
  // pin override: the serial function wins over the direction bits
  assign tx_o = tx_on ? s_q.transmit_shift_reg[0] : s_q.dir[DIR_TX_LAT];
  assign tx_oe_o = tx_on | ~s_q.dir[DIR_TX_IN];
  assign rx_o = s_q.dir[DIR_RX_LAT];
  assign rx_oe_o = ~rx_on & ~s_q.dir[DIR_RX_IN];

  property p_idle_mark;
    @(posedge clk_i) disable iff (!nrst_i)
    (tx_on && s_q.tx_st == TX_IDLE) |-> tx_o;
  endproperty
  a_idle_mark: assert property (p_idle_mark) else $error("idle tx line not at mark");

  property p_start_bit;
    @(posedge clk_i) disable iff (!nrst_i)
    load |=> (!tx_o && !shift_empty_status);
  endproperty
  a_start_bit: assert property (p_start_bit) else $error("no start bit after load");

  property p_gap;
    @(posedge clk_i) disable iff (!nrst_i)
    (s_q.tx_st == TX_GAP && tx_on) |=> (s_q.tx_st == TX_SHIFT && !s_q.hold_full);
  endproperty
  a_gap: assert property (p_gap) else $error("queued character not loaded after gap");

  property p_flag_lag;
    @(posedge clk_i) disable iff (!nrst_i)
    (do_wr && s_q.awaddr == ADDR_TXDATA && s_q.wstrb[0] && tx_on && s_q.tf1 &&
     s_q.tx_st == TX_SHIFT && !s_q.hold_full &&
     !(bt.tick[0] && s_q.tx_tk == TICK_LAST && s_q.tx_bits == tx_frame - 4'h1))
      |=> s_q.tflag ##1 s_q.tflag ##1 !s_q.tflag;
  endproperty
  a_flag_lag: assert property (p_flag_lag) else $error("empty flag timing wrong after write");

  property p_flag_off;
    @(posedge clk_i) disable iff (!nrst_i)
    !tx_on |=> ##1 !s_q.tflag;
  endproperty
  a_flag_off: assert property (p_flag_off) else $error("empty flag set while disabled");

  property p_false_start;
    @(posedge clk_i) disable iff (!nrst_i)
    (s_q.rx_st == RX_START && bt.tick[1] && s_q.rx_tk == HALF_LAST && s_q.line && !pop)
      |=> (s_q.rx_st == RX_IDLE && s_q.cnt == $past(s_q.cnt));
  endproperty
  a_false_start: assert property (p_false_start) else $error("false start not abandoned");

  property p_overrun;
    @(posedge clk_i) disable iff (!nrst_i)
    (s_q.ovr && rx_on) |-> (s_q.rx_st == RX_IDLE && !fall);
  endproperty
  a_overrun: assert property (p_overrun) else $error("reception continued after overrun");

  property p_fifo_cap;
    @(posedge clk_i) disable iff (!nrst_i)
    (push && s_q.cnt == 2'h2 && !pop) |=> (s_q.ovr && s_q.cnt == 2'h2);
  endproperty
  a_fifo_cap: assert property (p_fifo_cap) else $error("third character not flagged");

  property p_rx_off;
    @(posedge clk_i) disable iff (!nrst_i)
    !rx_on |=> (s_q.rx_st == RX_IDLE);
  endproperty
  a_rx_off: assert property (p_rx_off) else $error("receiver active while disabled");

  property p_pins;
    @(posedge clk_i) disable iff (!nrst_i)
    (tx_on |-> tx_oe_o) and (rx_on |-> !rx_oe_o);
  endproperty
  a_pins: assert property (p_pins) else $error("pin direction not overridden");
endmodule

// File: sim/usa_remote.sv
// remote asynchronous serial device facing the port's tx and rx pins
// assumes one character format at a time, set through nine by the bench
`timescale 1ns/1ps
module usa_remote #(
  parameter int BIT_CLKS = 32
) (
  input wire logic clk_i,
  input wire logic line_i,
  output logic line_o
);
  logic nine;
  logic prev;
  logic [9:0] got_q[$];
  int start_len;

  // captured frame layout: stop bit in bit 9, data lsb first from bit 0
  task automatic grab();
    logic [9:0] f;
    int c;
    int j;
    int nb;
    f = '0;
    nb = nine ? 10 : 9;
    start_len = 0;
    j = 0;
    for (c = 1; j <= nb; c++) begin
      @(posedge clk_i);
      if (start_len == 0 && line_i) begin
        start_len = c;
      end
      if (c == BIT_CLKS / 2 + j * BIT_CLKS) begin
        if (j == nb) begin
          f[9] = line_i;
        end else if (j > 0) begin
          f[j - 1] = line_i;
        end
        j++;
      end
    end
    got_q.push_back(f);
  endtask

  // start, data lsb first, stop, then idle at mark for one bit
  task automatic send(input logic [8:0] d, input int nbits, input logic stopv);
    int i;
    @(posedge clk_i);
    line_o <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk_i);
    for (i = 0; i < nbits; i++) begin
      line_o <= d[i];
      repeat (BIT_CLKS) @(posedge clk_i);
    end
    line_o <= stopv;
    repeat (BIT_CLKS) @(posedge clk_i);
    line_o <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk_i);
  endtask

  // a glitch too short to be a start bit
  task automatic glitch();
    @(posedge clk_i);
    line_o <= 1'b0;
    repeat (BIT_CLKS / 4) @(posedge clk_i);
    line_o <= 1'b1;
    repeat (2 * BIT_CLKS) @(posedge clk_i);
  endtask

  initial begin
    line_o = 1'b1;
    nine = 1'b0;
    prev = 1'b0;
    forever begin
      @(posedge clk_i);
      if (prev && !line_i) begin
        grab();
      end
      prev = line_i;
    end
  end
endmodule

// File: sim/usart_async_tx_rx_front_tb_top.sv
// self-checking bench for the asynchronous serial port
// assumes divisor 1, so one bit lasts 32 clocks
`timescale 1ns/1ps
module usart_async_tx_rx_front_tb_top;
  import usa_pkg::*;
  logic clk_i = 1'b0;
  logic nrst_i = 1'b0;
  logic [7:0] awaddr = '0;
  logic awvalid = 1'b0;
  logic awready;
  logic [31:0] wdata = '0;
  logic wvalid = 1'b0;
  logic wready;
  logic [1:0] bresp;
  logic bvalid;
  logic bready = 1'b0;
  logic [7:0] araddr = '0;
  logic arvalid = 1'b0;
  logic arready;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic rvalid;
  logic rready = 1'b0;
  logic tx_o, tx_oe_o, rx_i, rx_o, rx_oe_o;
  int failures = 0;
  int samples_checked = 0;

  always #20 clk_i = ~clk_i;

  usa_async_port dut (.clk_i(clk_i), .nrst_i(nrst_i),
    .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
    .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
    .s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
    .s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .tx_o(tx_o), .tx_oe_o(tx_oe_o),
    .rx_i(rx_i), .rx_o(rx_o), .rx_oe_o(rx_oe_o));

  usa_remote #(.BIT_CLKS(32)) u_rem (.clk_i(clk_i), .line_i(tx_o), .line_o(rx_i));

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic at, wt, bt;
    bt = 1'b0;
    r = 2'h2;
    @(posedge clk_i);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= d;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!bt) begin
      @(negedge clk_i);
      at = awvalid && awready;
      wt = wvalid && wready;
      bt = bvalid;
      if (bt) r = bresp;
      @(posedge clk_i);
      if (at) awvalid <= 1'b0;
      if (wt) wvalid <= 1'b0;
      if (bt) bready <= 1'b0;
    end
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic at, hit;
    hit = 1'b0;
    d = '0;
    r = 2'h2;
    @(posedge clk_i);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!hit) begin
      @(negedge clk_i);
      at = arvalid && arready;
      hit = rvalid;
      if (hit) begin
        d = rdata;
        r = rresp;
      end
      @(posedge clk_i);
      if (at) arvalid <= 1'b0;
      if (hit) rready <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic [1:0] r;
    axw(a, d, r);
    chk("bresp", {30'h0, er}, {30'h0, r});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] r;
    axr(a, d, r);
    chk("rresp", {30'h0, er}, {30'h0, r});
    if (er == RESP_OKAY) chk($sformatf("reg %h", a), exp, d);
  endtask

  task automatic frames(input int n);
    while (u_rem.got_q.size() < n) @(posedge clk_i);
    chk("frame count", 32'(n), 32'(u_rem.got_q.size()));
  endtask

  task automatic t_reset_and_map();
    chk("tx_oe reset", 32'h0, {31'h0, tx_oe_o});
    chk("rx_o reset", 32'h0, {31'h0, rx_o});
    rd(ADDR_TXCTL, 32'h2, RESP_OKAY);
    rd(ADDR_RXCTL, 32'h8, RESP_OKAY);
    rd(ADDR_BAUD, 32'h0, RESP_OKAY);
    rd(ADDR_DIR, 32'h3, RESP_OKAY);
    rd(ADDR_FLAG, 32'h0, RESP_OKAY);
    rd(8'h1c, 32'h0, RESP_DECERR);
    wr(8'h02, 32'hff, RESP_DECERR);
    wr(ADDR_FLAG, 32'h3, RESP_OKAY);
    rd(ADDR_FLAG, 32'h0, RESP_OKAY);
  endtask

  task automatic t_enable();
    wr(ADDR_DIR, 32'h9, RESP_OKAY);
    chk("rx_oe pin out", 32'h1, {31'h0, rx_oe_o});
    chk("rx latch", 32'h1, {31'h0, rx_o});
    // upper divisor byte must be ignored in 8-bit mode, so bits stay 32 clocks
    wr(ADDR_BAUD, 32'h101, RESP_OKAY);
    rd(ADDR_BAUD, 32'h101, RESP_OKAY);
    wr(ADDR_RXCTL, 32'h90, RESP_OKAY);
    chk("rx_oe forced in", 32'h0, {31'h0, rx_oe_o});
    wr(ADDR_TXCTL, 32'h20, RESP_OKAY);
    chk("tx_oe forced out", 32'h1, {31'h0, tx_oe_o});
    chk("tx idle mark", 32'h1, {31'h0, tx_o});
    rd(ADDR_FLAG, 32'h1, RESP_OKAY);
  endtask

  task automatic t_back_to_back();
    u_rem.got_q.delete();
    wr(ADDR_TXDATA, 32'h3c, RESP_OKAY);
    wr(ADDR_TXDATA, 32'ha5, RESP_OKAY);
    fork
      u_rem.send(9'h096, 8, 1'b1);
    join_none
    rd(ADDR_FLAG, 32'h0, RESP_OKAY);
    rd(ADDR_TXCTL, 32'h20, RESP_OKAY);
    frames(2);
    chk("frame 1", 32'h23c, {22'h0, u_rem.got_q[0]});
    chk("frame 2", 32'h2a5, {22'h0, u_rem.got_q[1]});
    chk("bit clocks", 32'd32, 32'(u_rem.start_len));
    repeat (100) @(posedge clk_i);
    rd(ADDR_TXCTL, 32'h22, RESP_OKAY);
    rd(ADDR_FLAG, 32'h3, RESP_OKAY);
    rd(ADDR_RXDATA, 32'h96, RESP_OKAY);
  endtask

  task automatic t_nine_bit();
    u_rem.got_q.delete();
    u_rem.nine = 1'b1;
    wr(ADDR_TXCTL, 32'h61, RESP_OKAY);
    wr(ADDR_TXDATA, 32'h55, RESP_OKAY);
    frames(1);
    chk("nine bit frame", 32'h355, {22'h0, u_rem.got_q[0]});
    // let the stop bit finish before the frame length changes
    repeat (32) @(posedge clk_i);
    rd(ADDR_TXCTL, 32'h63, RESP_OKAY);
    u_rem.nine = 1'b0;
    wr(ADDR_TXCTL, 32'h20, RESP_OKAY);
  endtask

  task automatic t_framing();
    wr(ADDR_RXCTL, 32'hd0, RESP_OKAY);
    u_rem.send(9'h1a5, 9, 1'b1);
    rd(ADDR_RXCTL, 32'hd9, RESP_OKAY);
    rd(ADDR_RXDATA, 32'ha5, RESP_OKAY);
    wr(ADDR_RXCTL, 32'h90, RESP_OKAY);
    u_rem.send(9'h0c3, 8, 1'b1);
    u_rem.send(9'h069, 8, 1'b0);
    rd(ADDR_RXCTL, 32'h98, RESP_OKAY);
    rd(ADDR_RXDATA, 32'hc3, RESP_OKAY);
    rd(ADDR_RXCTL, 32'h9c, RESP_OKAY);
    rd(ADDR_RXDATA, 32'h69, RESP_OKAY);
    u_rem.glitch();
    rd(ADDR_FLAG, 32'h1, RESP_OKAY);
  endtask

  task automatic t_overrun();
    u_rem.send(9'h011, 8, 1'b1);
    u_rem.send(9'h022, 8, 1'b1);
    u_rem.send(9'h033, 8, 1'b1);
    rd(ADDR_RXCTL, 32'h9a, RESP_OKAY);
    u_rem.send(9'h044, 8, 1'b1);
    rd(ADDR_RXDATA, 32'h11, RESP_OKAY);
    rd(ADDR_RXDATA, 32'h22, RESP_OKAY);
    rd(ADDR_FLAG, 32'h1, RESP_OKAY);
    wr(ADDR_RXCTL, 32'h80, RESP_OKAY);
    wr(ADDR_RXCTL, 32'h90, RESP_OKAY);
    rd(ADDR_RXCTL, 32'h98, RESP_OKAY);
    u_rem.send(9'h05a, 8, 1'b1);
    rd(ADDR_RXDATA, 32'h5a, RESP_OKAY);
  endtask

  task automatic t_disable();
    // synchronous select turns both asynchronous paths off
    wr(ADDR_TXCTL, 32'h30, RESP_OKAY);
    chk("tx_oe sync", 32'h0, {31'h0, tx_oe_o});
    chk("rx_oe sync", 32'h1, {31'h0, rx_oe_o});
    wr(ADDR_TXCTL, 32'h0, RESP_OKAY);
    chk("tx_oe released", 32'h0, {31'h0, tx_oe_o});
    rd(ADDR_FLAG, 32'h0, RESP_OKAY);
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // the tests need under 10000 clocks; the margin covers slow bus answers
  initial begin
    repeat (40000) @(posedge clk_i);
    failures++;
    test_done();
  end

  initial begin
    repeat (2) @(posedge clk_i);
    nrst_i <= 1'b1;
    t_reset_and_map();
    t_enable();
    t_back_to_back();
    t_nine_bit();
    t_framing();
    t_overrun();
    t_disable();
    test_done();
  end
endmodule
